// ---- core/pci_phase_if.sv ----
`timescale 1ns/1ns
// Shared bus wires; levels resolved from enables (low enable = driving)
interface pci_phase_if;
	logic [31:0] m_ad_o;
	logic m_ad_oe_n;
	logic [3:0] m_cbe_o;
	logic m_cbe_oe_n;
	logic m_par_o;
	logic m_par_oe_n;
	logic m_frame_n;
	logic m_irdy_n;
	logic m_lock_n;
	logic [31:0] t_ad_o;
	logic t_ad_oe_n;
	logic t_par_o;
	logic t_par_oe_n;
	logic t_devsel_n;
	logic t_trdy_n;
	logic t_devsel_oe_n;
	logic gnt_n;
	logic lock_sys_mode;
	// Resolved bus view (pull-ups where nobody drives)
	logic [31:0] ad;
	logic [3:0] cbe;
	logic par;
	assign ad = !m_ad_oe_n ? m_ad_o : (!t_ad_oe_n ? t_ad_o : 32'hFFFFFFFF);
	assign cbe = !m_cbe_oe_n ? m_cbe_o : 4'hF;
	assign par = !m_par_oe_n ? m_par_o : (!t_par_oe_n ? t_par_o : 1'b1);
	modport master (output m_ad_o, m_ad_oe_n, m_cbe_o, m_cbe_oe_n, m_par_o, m_par_oe_n, m_frame_n,
		m_irdy_n, m_lock_n, input ad, cbe, par, t_devsel_n, t_trdy_n, gnt_n, lock_sys_mode);
	modport target (output t_ad_o, t_ad_oe_n, t_par_o, t_par_oe_n, t_devsel_n, t_trdy_n, t_devsel_oe_n,
		input ad, cbe, par, m_frame_n, m_irdy_n, m_lock_n);
endinterface

// ---- core/pci_phase_master.sv ----
`timescale 1ns/1ns
// How it works
// - Address phase carries 32-bit address, low 4 bits zero when locked
// - Byte lane 0 is least significant
// - Word moves only when IRDY and TRDY
// - Write data stable while IRDY asserted
// - Address phase C/BE carries command
// - Data phase C/BE are active-low enables
// - Enable bit n qualifies byte lane n
// - Codes 0-3: intack, special, IO rd/wr
// - Codes 6,7,F: memory rd, wr, wr-inv
// - Code C is memory read multiple
// - Codes 4, 8, D reserved, never issued
// - PAR makes total ones count even
// - Master drives PAR address and write
// - Address parity one clock after address
// - Data parity one clock after ready
// - Parity held one clock past phase
// - Lock covers at least 16 bytes
// - Grant alone does not own lock
// - System lock blocks issue while own LOCK driven, unowned
// - DEVSEL input means some target selected
// - Subtractive decoder also drives DEVSEL
// - No DEVSEL by deadline gives master abort, except special cycle
module pci_phase_master #(
	parameter int DEVSEL_CLKS = pci_phase_pkg::DEVSEL_WAIT_CLKS
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Request from host logic
	input wire logic I_REQ_VALID,
	output logic O_REQ_READY,
	input wire logic [3:0] I_REQ_CMD,
	input wire logic [31:0] I_REQ_ADDR,
	input wire logic [31:0] I_REQ_WDATA,
	input wire logic [3:0] I_REQ_BE_N,
	input wire logic I_REQ_LOCK,
	// Answer to host logic
	output logic O_RSP_VALID,
	input wire logic I_RSP_READY,
	output logic [31:0] O_RSP_RDATA,
	output logic O_RSP_ABORT,
	output logic O_LOCK_OWNED,
	// Bus side
	pci_phase_if.master bus
);
	typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_TURN, ST_RESP} mst_state_t;
	mst_state_t state_reg;
	logic [3:0] cmd_reg;
	logic [31:0] wdata_reg;
	logic [3:0] be_reg;
	logic lock_reg;
	logic [2:0] wait_reg;
	logic par_pend_reg;
	logic par_next;
	logic xfer;
	logic [31:0] skid_data [0:1];
	logic [1:0] skid_abort;
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic push;
	logic take;
	logic pop;

	// ----------------------------------------------------------------
	// Transfer detection
	// ----------------------------------------------------------------
	// Word moves only on a clock with both ready lines low
	assign xfer = (state_reg == ST_DATA) && !bus.m_irdy_n && !bus.t_trdy_n;
	// Ready is registered, so it may still stand from an issuable code when a
	// reserved one arrives; the code is checked again at the taking edge
	assign take = (state_reg == ST_IDLE) && I_REQ_VALID && O_REQ_READY &&
		!pci_phase_pkg::is_reserved(I_REQ_CMD);
	// Parity covers what we put on AD/CBE this cycle
	assign par_next = pci_phase_pkg::even_par(bus.m_ad_o, bus.m_cbe_o);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Issue only when the answer buffer has room, so no word is dropped
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_reg <= ST_IDLE;
			cmd_reg <= pci_phase_pkg::CMD_MEM_RD;
			wdata_reg <= 32'h00000000;
			be_reg <= pci_phase_pkg::BE_NONE;
			lock_reg <= 1'b0;
			wait_reg <= 3'h0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// Reserved codes are refused silently; grant needed too
					if (take) begin
						cmd_reg <= I_REQ_CMD;
						wdata_reg <= I_REQ_WDATA;
						be_reg <= I_REQ_BE_N;
						lock_reg <= I_REQ_LOCK;
						state_reg <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					wait_reg <= 3'h0;
					state_reg <= ST_DATA;
				end
				ST_DATA: begin
					if (xfer) begin
						state_reg <= ST_TURN;
					end else if (bus.t_devsel_n && cmd_reg != pci_phase_pkg::CMD_SPECIAL) begin
						if (32'(wait_reg) >= DEVSEL_CLKS - 1) begin
							state_reg <= ST_TURN;
						end else begin
							wait_reg <= wait_reg + 3'h1;
						end
					end else if (cmd_reg == pci_phase_pkg::CMD_SPECIAL && 32'(wait_reg) >= DEVSEL_CLKS - 1) begin
						state_reg <= ST_TURN;
					end else if (cmd_reg == pci_phase_pkg::CMD_SPECIAL) begin
						wait_reg <= wait_reg + 3'h1;
					end
				end
				ST_TURN: state_reg <= ST_RESP;
				ST_RESP: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Bus drivers
	// ----------------------------------------------------------------
	// Address and command in the address phase, data and enables after
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			bus.m_ad_o <= 32'h00000000;
			bus.m_ad_oe_n <= 1'b1;
			bus.m_cbe_o <= pci_phase_pkg::BE_NONE;
			bus.m_cbe_oe_n <= 1'b1;
			bus.m_frame_n <= 1'b1;
			bus.m_irdy_n <= 1'b1;
		end else begin
			bus.m_frame_n <= 1'b1;
			if (take) begin
				bus.m_frame_n <= 1'b0;
				// A locked access starts on a 16-byte boundary, so the whole region is covered
				bus.m_ad_o <= I_REQ_LOCK ? {I_REQ_ADDR[31:pci_phase_pkg::LOCK_ADDR_LSB], 4'h0} : I_REQ_ADDR;
				bus.m_ad_oe_n <= 1'b0;
				bus.m_cbe_o <= I_REQ_CMD;
				bus.m_cbe_oe_n <= 1'b0;
			end else if (state_reg == ST_ADDR) begin
				// Single data phase: frame rises as irdy falls
				bus.m_irdy_n <= 1'b0;
				bus.m_cbe_o <= be_reg;
				bus.m_ad_o <= wdata_reg;
				bus.m_ad_oe_n <= pci_phase_pkg::is_read(cmd_reg);
			end else if (state_reg == ST_DATA && !xfer && !(state_reg == ST_DATA &&
				bus.t_devsel_n && 32'(wait_reg) >= DEVSEL_CLKS - 1)) begin
				bus.m_irdy_n <= 1'b0;
			end else if (state_reg != ST_IDLE) begin
				bus.m_irdy_n <= 1'b1;
				bus.m_ad_oe_n <= 1'b1;
				bus.m_cbe_oe_n <= 1'b1;
			end
		end
	end

	// Parity lags AD/CBE by one clock and is held one clock past the phase
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			bus.m_par_o <= 1'b0;
			bus.m_par_oe_n <= 1'b1;
			par_pend_reg <= 1'b0;
		end else begin
			par_pend_reg <= !bus.m_ad_oe_n;
			if (!bus.m_ad_oe_n || (!bus.m_cbe_oe_n && state_reg == ST_ADDR)) begin
				bus.m_par_o <= par_next;
				bus.m_par_oe_n <= 1'b0;
			end else if (par_pend_reg) begin
				bus.m_par_oe_n <= 1'b0;
			end else begin
				bus.m_par_oe_n <= 1'b1;
			end
		end
	end

	// Lock is ours only after a locked transfer is claimed, not on grant
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			bus.m_lock_n <= 1'b1;
			O_LOCK_OWNED <= 1'b0;
		end else if (state_reg == ST_ADDR && lock_reg) begin
			bus.m_lock_n <= 1'b0;
		end else if (xfer && lock_reg) begin
			O_LOCK_OWNED <= 1'b1;
		end else if (take && !I_REQ_LOCK) begin
			bus.m_lock_n <= 1'b1;
			O_LOCK_OWNED <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Answer buffer (two entries)
	// ----------------------------------------------------------------
	assign push = (state_reg == ST_TURN);
	assign pop = O_RSP_VALID && I_RSP_READY;

	// Read data and abort status captured at the end of the phase
	always_ff @(posedge I_CLK) begin
		if (xfer) begin
			skid_data[wr_ptr_reg] <= bus.ad;
		end
	end

	// Abort flag per entry: set when the phase ended without a transfer
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			skid_abort <= 2'h0;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			// A special cycle expects no claim, so running out of time is no abort there
			if (state_reg == ST_DATA && !xfer) begin
				skid_abort[wr_ptr_reg] <= (cmd_reg != pci_phase_pkg::CMD_SPECIAL);
			end else if (xfer) begin
				skid_abort[wr_ptr_reg] <= 1'b0;
			end
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// Registered answer and request handshake
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_RSP_VALID <= 1'b0;
			O_RSP_RDATA <= 32'h00000000;
			O_RSP_ABORT <= 1'b0;
			O_REQ_READY <= 1'b0;
		end else begin
			O_RSP_VALID <= (count_reg - {1'b0, pop}) != 2'h0;
			O_RSP_RDATA <= skid_data[pop ? ~rd_ptr_reg : rd_ptr_reg];
			O_RSP_ABORT <= skid_abort[pop ? ~rd_ptr_reg : rd_ptr_reg];
			// Blocked in system lock mode while our own LOCK is driven but not yet owned, or no grant
			O_REQ_READY <= (state_reg == ST_IDLE) && !(O_REQ_READY && I_REQ_VALID) &&
				!bus.gnt_n && count_reg == 2'h0 && !pci_phase_pkg::is_reserved(I_REQ_CMD) &&
				!(bus.lock_sys_mode && !O_LOCK_OWNED && !bus.m_lock_n);
		end
	end
endmodule // pci_phase_master

// ---- core/pci_phase_pkg.sv ----
package pci_phase_pkg;
	// ----------------------------------------------------------------
	// Bus commands
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_INT_ACK = 4'h0;
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_RSVD_4 = 4'h4;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_RSVD_8 = 4'h8;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
	localparam logic [3:0] CMD_DUAL_ADDR = 4'hD;
	localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

	// ----------------------------------------------------------------
	// Timing and sizes
	// ----------------------------------------------------------------
	localparam int DEVSEL_WAIT_CLKS = 4;
	localparam logic [2:0] DEVSEL_WAIT = 3'h4;
	localparam int LOCK_MIN_BYTES = 16;
	localparam int LOCK_ADDR_LSB = 4;
	localparam logic [3:0] BE_ALL = 4'h0;
	localparam logic [3:0] BE_NONE = 4'hF;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Even parity over AD and C/BE#
	function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
		even_par = ^{ad, cbe};
	endfunction

	// Commands that move data from the target to the master
	function automatic logic is_read(input logic [3:0] cmd);
		is_read = (cmd == CMD_INT_ACK) || (cmd == CMD_IO_RD) || (cmd == CMD_MEM_RD) ||
			(cmd == CMD_CFG_RD) || (cmd == CMD_MEM_RD_MULT);
	endfunction

	// Reserved codes are never issued and never claimed
	function automatic logic is_reserved(input logic [3:0] cmd);
		is_reserved = (cmd == CMD_RSVD_4) || (cmd == CMD_RSVD_8) || (cmd == CMD_DUAL_ADDR) ||
			(cmd == 4'h5) || (cmd == 4'h9) || (cmd == 4'hE);
	endfunction
endpackage

// ---- core/pci_phase_target.sv ----
`timescale 1ns/1ns
// Target end: claims an address window, or every non-special, non-reserved cycle when subtractive
module pci_phase_target #(
	parameter logic [31:0] BASE = 32'h00000000,
	parameter logic [31:0] MASK = 32'hFFFFF000,
	parameter bit SUBTRACTIVE = 1'b0
) (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Read data supply and write data sink
	input wire logic [31:0] I_RDATA,
	input wire logic I_TRDY_EN,
	output logic O_WR_VALID,
	output logic [31:0] O_WR_DATA,
	output logic [3:0] O_WR_BE_N,
	output logic [31:0] O_ADDR,
	output logic [3:0] O_CMD,
	// Bus side
	pci_phase_if.target bus
);
	logic active_reg;
	logic read_reg;
	logic [1:0] delay_reg;
	logic par_hold_reg;
	logic hit;
	logic xfer;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Subtractive decode claims late, so positive decoders win first
	assign hit = ((bus.ad & MASK) == BASE || SUBTRACTIVE) && !pci_phase_pkg::is_reserved(bus.cbe) &&
		bus.cbe != pci_phase_pkg::CMD_SPECIAL;
	assign xfer = active_reg && !bus.m_irdy_n && !bus.t_trdy_n;

	// Claim state, DEVSEL and TRDY
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			active_reg <= 1'b0;
			read_reg <= 1'b0;
			delay_reg <= 2'h0;
			bus.t_devsel_n <= 1'b1;
			bus.t_devsel_oe_n <= 1'b1;
			bus.t_trdy_n <= 1'b1;
			O_ADDR <= 32'h00000000;
			O_CMD <= pci_phase_pkg::CMD_MEM_RD;
		end else if (!active_reg && !bus.m_frame_n) begin
			active_reg <= hit;
			read_reg <= pci_phase_pkg::is_read(bus.cbe);
			delay_reg <= SUBTRACTIVE ? 2'h2 : 2'h0;
			O_ADDR <= bus.ad;
			O_CMD <= bus.cbe;
		end else if (active_reg) begin
			if (delay_reg != 2'h0) begin
				delay_reg <= delay_reg - 2'h1;
			end else begin
				bus.t_devsel_n <= 1'b0;
				bus.t_devsel_oe_n <= 1'b0;
				bus.t_trdy_n <= !I_TRDY_EN;
			end
			if (xfer) begin
				active_reg <= 1'b0;
				bus.t_devsel_n <= 1'b1;
				bus.t_trdy_n <= 1'b1;
			end
		end else begin
			bus.t_devsel_oe_n <= 1'b1;
		end
	end

	// Read data driven from the clock after a read is decoded through its transfer clock, parity one clock later and held one more
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			bus.t_ad_o <= 32'h00000000;
			bus.t_ad_oe_n <= 1'b1;
			bus.t_par_o <= 1'b0;
			bus.t_par_oe_n <= 1'b1;
			par_hold_reg <= 1'b0;
		end else begin
			bus.t_ad_oe_n <= !(active_reg && read_reg && !xfer);
			bus.t_ad_o <= I_RDATA;
			par_hold_reg <= !bus.t_ad_oe_n;
			if (!bus.t_ad_oe_n) begin
				bus.t_par_o <= pci_phase_pkg::even_par(bus.t_ad_o, bus.cbe);
				bus.t_par_oe_n <= 1'b0;
			end else begin
				bus.t_par_oe_n <= !par_hold_reg;
			end
		end
	end

	// Write data handed to the user one clock after the transfer clock
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_WR_VALID <= 1'b0;
			O_WR_DATA <= 32'h00000000;
			O_WR_BE_N <= pci_phase_pkg::BE_NONE;
		end else begin
			O_WR_VALID <= xfer && !read_reg;
			O_WR_DATA <= bus.ad;
			O_WR_BE_N <= bus.cbe;
		end
	end
endmodule // pci_phase_target

// ---- verif/pci_phase_sva.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bus phase checks between master and target ends
// ----------------------------------------------------------------
module pci_phase_sva (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Master drive
	input wire logic [31:0] m_ad_o,
	input wire logic m_ad_oe_n,
	input wire logic [3:0] m_cbe_o,
	input wire logic m_cbe_oe_n,
	input wire logic m_par_oe_n,
	input wire logic m_frame_n,
	input wire logic m_irdy_n,
	// Target drive
	input wire logic t_ad_oe_n,
	input wire logic t_par_oe_n,
	input wire logic t_devsel_n,
	input wire logic t_trdy_n,
	// Resolved bus
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe,
	input wire logic par
);
	// One clock domain, so one clocking and one disable for all checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	// Address phase: every AD and C/BE line driven, never reserved code 4, 8 or D
	addr_drive_a: assert property ($fell(m_frame_n) |-> !m_ad_oe_n && !m_cbe_oe_n)
		else $error("address phase lines not driven");
	cmd_legal_a: assert property ($fell(m_frame_n) |-> !(cbe inside {4'h4, 4'h8, 4'hD}))
		else $error("reserved command issued");
	// Parity follows one clock later, address parity from the master
	addr_par_a: assert property ($fell(m_frame_n) |=> !m_par_oe_n && par == ^{$past(ad), $past(cbe)})
		else $error("address parity wrong");
	data_par_a: assert property (!m_irdy_n && !t_trdy_n |=> par == ^{$past(ad), $past(cbe)})
		else $error("data parity wrong");
	// Waiting write phase keeps data and enables steady
	wr_hold_a: assert property (!m_irdy_n && t_trdy_n && !m_ad_oe_n |=>
		m_irdy_n || ($stable(m_ad_o) && $stable(m_cbe_o)))
		else $error("write data moved while waiting");
	irdy_wait_a: assert property (!m_irdy_n && t_trdy_n && !t_devsel_n |=> !m_irdy_n)
		else $error("master left phase before transfer");
	// Read data and its parity come from the target only
	rd_drive_a: assert property (!t_trdy_n && m_ad_oe_n |-> !t_ad_oe_n)
		else $error("read data not driven by target");
	rd_par_a: assert property (!m_irdy_n && !t_trdy_n && m_ad_oe_n |=> !t_par_oe_n && m_par_oe_n)
		else $error("read parity driver wrong");
	// Two drivers on one line would hide every other fault
	no_clash_a: assert property ((m_ad_oe_n || t_ad_oe_n) && (m_par_oe_n || t_par_oe_n))
		else $error("both ends drive the bus");
	// Unclaimed phase must end by master abort well before eight clocks
	abort_bound_a: assert property ((!m_irdy_n && t_devsel_n)[*8] |-> 1'b0)
		else $error("unclaimed cycle never aborted");
endmodule // pci_phase_sva

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk, rst_n, req_valid, req_ready, req_lock, rsp_valid, rsp_ready, rsp_abort, lock_owned;
	logic trdy_en, wr_valid, ab;
	logic m2_valid, m2_ready, m2_rsp_valid, m2_abort;
	logic [31:0] m2_rdata;
	logic [3:0] req_cmd, req_be_n, wr_be_n, t_cmd, got_be_n;
	logic [31:0] req_addr, req_wdata, rsp_rdata, rdata_in, wr_data, t_addr, got_data, rd;
	logic [3:0] cmds [8] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hC, 4'hF};
	logic wr_of [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [3:0] rsv [3] = '{4'h4, 4'h8, 4'hD};
	int miscompares = 0;
	int tests_run = 0;
	int frame_falls = 0;
	int f;
	pci_phase_if bus_if ();
	pci_phase_master #(.DEVSEL_CLKS(4)) pci_phase_master_inst (.I_CLK(clk), .I_RST_N(rst_n),
		.I_REQ_VALID(req_valid), .O_REQ_READY(req_ready), .I_REQ_CMD(req_cmd), .I_REQ_ADDR(req_addr),
		.I_REQ_WDATA(req_wdata), .I_REQ_BE_N(req_be_n), .I_REQ_LOCK(req_lock), .O_RSP_VALID(rsp_valid),
		.I_RSP_READY(rsp_ready), .O_RSP_RDATA(rsp_rdata), .O_RSP_ABORT(rsp_abort), .O_LOCK_OWNED(lock_owned),
		.bus(bus_if.master));
	pci_phase_target #(.BASE(32'h00010000), .MASK(32'hFFFFF000), .SUBTRACTIVE(1'b0)) pci_phase_target_inst (
		.I_CLK(clk), .I_RST_N(rst_n), .I_RDATA(rdata_in), .I_TRDY_EN(trdy_en), .O_WR_VALID(wr_valid),
		.O_WR_DATA(wr_data), .O_WR_BE_N(wr_be_n), .O_ADDR(t_addr), .O_CMD(t_cmd), .bus(bus_if.target));
	// Second pair on its own bus: a subtractive agent that claims every cycle but special and reserved-code cycles, late
	pci_phase_if bus2_if ();
	pci_phase_master #(.DEVSEL_CLKS(4)) pci_phase_master_sub_inst (.I_CLK(clk), .I_RST_N(rst_n),
		.I_REQ_VALID(m2_valid), .O_REQ_READY(m2_ready), .I_REQ_CMD(req_cmd), .I_REQ_ADDR(req_addr),
		.I_REQ_WDATA(req_wdata), .I_REQ_BE_N(req_be_n), .I_REQ_LOCK(req_lock), .O_RSP_VALID(m2_rsp_valid),
		.I_RSP_READY(rsp_ready), .O_RSP_RDATA(m2_rdata), .O_RSP_ABORT(m2_abort), .O_LOCK_OWNED(),
		.bus(bus2_if.master));
	pci_phase_target #(.BASE(32'h00010000), .MASK(32'hFFFFF000), .SUBTRACTIVE(1'b1))
		pci_phase_target_sub_inst (.I_CLK(clk), .I_RST_N(rst_n), .I_RDATA(rdata_in), .I_TRDY_EN(trdy_en),
		.O_WR_VALID(), .O_WR_DATA(), .O_WR_BE_N(), .O_ADDR(), .O_CMD(), .bus(bus2_if.target));
	pci_phase_sva pci_phase_sva_inst (.I_CLK(clk), .I_RST_N(rst_n), .m_ad_o(bus_if.m_ad_o),
		.m_ad_oe_n(bus_if.m_ad_oe_n), .m_cbe_o(bus_if.m_cbe_o), .m_cbe_oe_n(bus_if.m_cbe_oe_n),
		.m_par_oe_n(bus_if.m_par_oe_n), .m_frame_n(bus_if.m_frame_n), .m_irdy_n(bus_if.m_irdy_n),
		.t_ad_oe_n(bus_if.t_ad_oe_n), .t_par_oe_n(bus_if.t_par_oe_n), .t_devsel_n(bus_if.t_devsel_n),
		.t_trdy_n(bus_if.t_trdy_n), .ad(bus_if.ad), .cbe(bus_if.cbe), .par(bus_if.par));

	// ----------------------------------------------------------------
	// Clock, monitors and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Latch each write handed out, since the strobe stands one cycle only
	always @(posedge clk) begin
		if (wr_valid === 1'b1) begin
			got_data <= wr_data;
			got_be_n <= wr_be_n;
		end
	end
	always @(negedge bus_if.m_frame_n) frame_falls++;
	// About 14 transfers of some 20 clocks each; fourteen times that is a hang
	initial begin
		#40000;
		miscompares++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One whole transaction; the host side holds off its answer for stall clocks
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wdata,
		input logic [3:0] be_n, input logic lock, input int stall);
		int n;
		n = 0;
		req_cmd = cmd;
		req_addr = addr;
		req_wdata = wdata;
		req_be_n = be_n;
		req_lock = lock;
		req_valid = 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		#1 req_valid = 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 100);
		check("rsp_valid", rsp_valid, 1'b1);
		rd = rsp_rdata;
		ab = rsp_abort;
		repeat (stall) @(posedge clk);
		check("rsp_hold", rsp_valid, 1'b1);
		#1 rsp_ready = 1'b1;
		@(posedge clk);
		#1 rsp_ready = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		{req_valid, req_lock, rsp_ready} = 3'h0;
		{req_cmd, req_be_n} = 8'h00;
		{req_addr, req_wdata} = 64'h0;
		rdata_in = 32'h00000000;
		trdy_en = 1'b1;
		bus_if.gnt_n = 1'b0;
		bus_if.lock_sys_mode = 1'b0;
		bus2_if.gnt_n = 1'b0;
		bus2_if.lock_sys_mode = 1'b0;
		m2_valid = 1'b0;
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		// Partial write: lanes and enables must keep their order
		xfer(pci_phase_pkg::CMD_MEM_WR, 32'h00010004, 32'h8899AABB, 4'hA, 1'b0, 0);
		check("wr_data", got_data, 32'h8899AABB);
		check("wr_be_n", got_be_n, 4'hA);
		check("addr", t_addr, 32'h00010004);
		check("abort", ab, 1'b0);
		check("lock_owned", lock_owned, 1'b0);
		// Read with a slow target and a slow host
		trdy_en = 1'b0;
		rdata_in = 32'hC0DE1234;
		fork
			begin
				repeat (6) @(posedge clk);
				#1 trdy_en = 1'b1;
			end
		join_none
		xfer(pci_phase_pkg::CMD_MEM_RD, 32'h00010008, 32'h0, 4'h0, 1'b0, 3);
		check("rd_stall", rd, 32'hC0DE1234);
		// Every issuable command but 0 and 1 reaches the target with its own code
		for (int i = 0; i < 8; i++) begin
			rdata_in = 32'h5A000000 | i;
			xfer(cmds[i], 32'h00010010 + 4 * i, 32'hA5000000 | i, 4'h0, 1'b0, 0);
			check("cmd", t_cmd, cmds[i]);
			if (wr_of[i]) begin
				check("wr_cmd_data", got_data, 32'hA5000000 | i);
			end else begin
				check("rd_cmd_data", rd, 32'h5A000000 | i);
			end
		end
		// Reserved codes 4, 8 and D never start a transaction
		for (int i = 0; i < 3; i++) begin
			f = frame_falls;
			req_cmd = rsv[i];
			req_valid = 1'b1;
			repeat (10) @(posedge clk);
			#1 req_valid = 1'b0;
			check("rsv_frame", frame_falls, f);
			// Let an edge pass before valid rises again
			@(posedge clk);
			#1;
		end
		// Nobody claims this address: master abort
		xfer(pci_phase_pkg::CMD_MEM_RD, 32'h00020000, 32'h0, 4'h0, 1'b0, 0);
		check("abort_out", ab, 1'b1);
		// Special cycle expects no claim and is not aborted
		xfer(pci_phase_pkg::CMD_SPECIAL, 32'h00000000, 32'h12345678, 4'h0, 1'b0, 0);
		check("special", ab, 1'b0);
		// Lock is owned only after its own locked transfer
		xfer(pci_phase_pkg::CMD_MEM_WR, 32'h00010104, 32'h0F0F0F0F, 4'h0, 1'b1, 0);
		check("lock_got", lock_owned, 1'b1);
		check("lock_addr", t_addr, 32'h00010100);
		// Subtractive agent claims late yet inside the deadline: data, no abort
		req_lock = 1'b0;
		req_cmd = pci_phase_pkg::CMD_MEM_RD;
		req_addr = 32'h00020000;
		rdata_in = 32'h600DF00D;
		m2_valid = 1'b1;
		@(posedge clk);
		check("sub_take", m2_ready, 1'b1);
		#1 m2_valid = 1'b0;
		repeat (12) @(posedge clk);
		check("sub_valid", m2_rsp_valid, 1'b1);
		check("sub_abort", m2_abort, 1'b0);
		check("sub_data", m2_rdata, 32'h600DF00D);
		#1 rsp_ready = 1'b1;
		@(posedge clk);
		#1 rsp_ready = 1'b0;
		close_out();
	end
endmodule // tb
